// >>> src/expc_top.sv
// Exposure and frame capture control: shutter, long exposure, single,
// counted and free-run capture, trigger arming and broadcast writes.
// Assumes requests arrive one per cycle, synchronous to clk.
// Operation
// [RULE1] Exposure equals shutter times base plus offset
// [RULE2] Host writes shutter values one to 4095
// [RULE3] Time base is twenty microseconds after reset
// [RULE4] Fixed offset added; minimum requested is 4 us
// [RULE5] Long exposure field counts microseconds, 26 bits
// [RULE6] Long exposure reaches about 67 seconds
// [RULE7] Shutter write mirrors into long exposure field
// [RULE8] Long exposure changes take effect at once
// [RULE9] Format, mode or rate write drops long exposure
// [RULE10] Single-frame bit clears itself after capture
// [RULE11] Free-run ignores the single-frame bit
// [RULE12] With trigger, single-frame arms; clearing cancels
// [RULE13] Host enables trigger, stops free-run, requests frame
// [RULE14] Sync within 150 us, integration 8 us later
// [RULE15] Sync starts exposure or enables trigger path
// [RULE16] First packet 710 us after exposure, bus-aligned
// [RULE17] Multi-frame captures the programmed image count
// [RULE18] Multi-frame flag self-clears; free-run ignores it
// [RULE19] Clearing flag or zero count stops multi-frame
// [RULE20] Multi-frame works with external trigger
// [RULE21] Free-run bit starts and stops endless capture
// [RULE22] Broadcast node writes accepted without acknowledgment
`timescale 1ns/1ps
`include "expc_params.svh"
module expc_top
  import expc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [5:0]  own_node,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [5:0]  req_node,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] req_wdata,
  output logic             rsp_valid,
  output logic [31:0]      rsp_rdata,
  input  wire logic        trig_in,
  output logic             sync_pulse,
  output logic             external_exposure_sync,
  output logic             exposing,
  output logic             frm_valid,
  input  wire logic        frm_ready,
  output logic [15:0]      frm_data
);
  // ========================================================================
  // State record
  typedef struct packed {
    expc_state_e                 st;
    logic [`EXPC_W_SHUT-1:0]     shut;
    logic [`EXPC_W_TBASE-1:0]    tbase;
    logic [`EXPC_W_LONG-1:0]     long_exposure_us;
    logic                        long_act;
    logic                        single;
    logic                        multi;
    logic [`EXPC_W_COUNT-1:0]    count;
    logic                        continuous_capture_bit;
    logic                        trig_on;
    logic                        trig_prev;
    logic                        rsp;
    logic [31:0]                 rdata;
    logic                        sync;
    logic                        ext_sync;
    logic                        expo;
    logic [26:0]                 exp_cnt;
    logic [6:0]                  cyc;
    logic [15:0]                 frame;
    logic                        push;
  } expc_top_s;
  expc_top_s s_q, s_d;

  logic       us_tick;
  logic       tmr_done;
  logic       tmr_ld;
  logic [9:0] tmr_us;
  expc_if     bif ();

  // ========================================================================
  // Helpers

  // Effective exposure in microseconds including the model offset.
  function automatic logic [26:0] exp_total(input expc_top_s s);
    logic [25:0] base;
    base = s.long_act ? s.long_exposure_us : 26'(s.shut * s.tbase);
    if (base < 26'(`EXPC_MIN_EXP_US)) begin
      base = 26'(`EXPC_MIN_EXP_US);
    end
    return 27'(base) + 27'(`EXPC_OFFSET_US);
  endfunction : exp_total

  // True when any capture request still wants a frame.
  function automatic logic want_frame(input expc_top_s s);
    return s.continuous_capture_bit || s.single || (s.multi && s.count != '0);
  endfunction : want_frame

  // ========================================================================
  // Register access, capture sequencer and bus cycle alignment
  always_comb begin
    logic is_bcast;
    logic hit;
    logic wr;
    is_bcast = (req_node == `EXPC_BCAST_NODE);
    hit      = req_valid && (is_bcast || req_node == own_node);
    wr       = hit && req_write;
    s_d      = s_q;
    s_d.rsp  = 1'b0;
    s_d.sync = 1'b0;
    s_d.push = s_q.push && !bif.ready;
    s_d.trig_prev = trig_in;
    tmr_ld   = 1'b0;
    tmr_us   = 10'h000;

    // Free-running 125 us bus cycle counter.
    if (us_tick) begin
      s_d.cyc = (s_q.cyc == 7'(`EXPC_BUS_CYC_US - 1)) ? 7'h00 : s_q.cyc + 7'h01;
    end

    // Sequencer; hardware clears come before host writes so a write wins.
    case (s_q.st)
      EXPC_IDLE: begin
        if (want_frame(s_q) && !s_q.push) begin
          s_d.st = EXPC_SYNC;
        end
      end
      EXPC_SYNC: begin
        if (us_tick) begin
          s_d.sync = 1'b1;                               // RULE14
          if (s_q.trig_on) begin
            s_d.ext_sync = 1'b1;                         // RULE15
            s_d.st       = EXPC_ARM;                     // RULE12 RULE20
          end else begin
            tmr_ld = 1'b1;
            tmr_us = 10'(`EXPC_LEAD_US);                 // RULE15
            s_d.st = EXPC_LEAD;
          end
        end
      end
      EXPC_ARM: begin
        if (!want_frame(s_q)) begin
          s_d.ext_sync = 1'b0;                           // RULE12 RULE19
          s_d.st       = EXPC_IDLE;
        end else if (trig_in && !s_q.trig_prev) begin
          s_d.ext_sync = 1'b0;
          tmr_ld       = 1'b1;
          tmr_us       = 10'(`EXPC_LEAD_US);             // RULE14
          s_d.st       = EXPC_LEAD;
        end
      end
      EXPC_LEAD: begin
        if (tmr_done) begin
          s_d.expo    = 1'b1;
          s_d.exp_cnt = '0;
          s_d.st      = EXPC_EXPO;
        end
      end
      EXPC_EXPO: begin
        if (us_tick) begin
          s_d.exp_cnt = s_q.exp_cnt + 27'h1;
          // Compared live, so a new long exposure acts at once.
          if (s_q.exp_cnt + 27'h1 >= exp_total(s_q)) begin  // RULE1 RULE4 RULE8
            s_d.expo = 1'b0;
            tmr_ld   = 1'b1;
            tmr_us   = 10'(`EXPC_XFER_MIN_US);           // RULE16
            s_d.st   = EXPC_READ;
          end
        end
      end
      EXPC_READ: begin
        if (tmr_done) begin
          s_d.st = EXPC_SEND;
        end
      end
      EXPC_SEND: begin
        // Send on a bus cycle boundary; the wait gives the cycle jitter.
        if (us_tick && s_q.cyc == 7'h00 && !s_q.push) begin  // RULE16
          s_d.push  = 1'b1;
          s_d.frame = s_q.frame + 16'h0001;
          s_d.st    = EXPC_IDLE;
          if (!s_q.continuous_capture_bit) begin         // RULE11 RULE18
            if (s_q.multi && s_q.count != '0) begin
              s_d.count = s_q.count - 16'h0001;          // RULE17
              if (s_q.count == 16'h0001) begin
                s_d.multi = 1'b0;                        // RULE18
              end
            end else begin
              s_d.single = 1'b0;                         // RULE10
            end
          end
        end
      end
      default: begin
        s_d.st = EXPC_IDLE;
      end
    endcase

    // Host writes, unicast or broadcast alike.
    if (wr) begin                                        // RULE22
      case (req_addr)
        `EXPC_A_SHUTTER: begin
          s_d.shut = req_wdata[`EXPC_W_SHUT-1:0];        // RULE2
          s_d.long_exposure_us = 26'(req_wdata[`EXPC_W_SHUT-1:0] * s_q.tbase);  // RULE7
          s_d.long_act = 1'b0;
        end
        `EXPC_A_TBASE: begin
          s_d.tbase = req_wdata[`EXPC_W_TBASE-1:0];      // RULE3
        end
        `EXPC_A_LONG_EXP: begin
          s_d.long_exposure_us = req_wdata[`EXPC_W_LONG-1:0];  // RULE5 RULE6
          s_d.long_act = 1'b1;                           // RULE7
        end
        `EXPC_A_FMT_RATE, `EXPC_A_FMT_MODE, `EXPC_A_FMT_FORMAT: begin
          s_d.long_act = 1'b0;                           // RULE9
        end
        `EXPC_A_ACQ: begin
          s_d.single = req_wdata[`EXPC_B_MSB];           // RULE10 RULE12
          s_d.multi  = req_wdata[`EXPC_B_MULTI];         // RULE19
          s_d.count  = req_wdata[`EXPC_W_COUNT-1:0];     // RULE17 RULE19
        end
        `EXPC_A_FREE_RUN: begin
          s_d.continuous_capture_bit = req_wdata[`EXPC_B_MSB];  // RULE21
        end
        `EXPC_A_TRIG: begin
          s_d.trig_on = req_wdata[`EXPC_B_TRIG_ON];      // RULE13
        end
        default: begin
        end
      endcase
    end

    // Reads and acknowledgments go to the own node only.
    if (hit && !is_bcast) begin                          // RULE22
      s_d.rsp   = 1'b1;
      s_d.rdata = 32'h0000_0000;
      if (!req_write) begin
        case (req_addr)
          `EXPC_A_SHUTTER:  s_d.rdata = 32'(s_q.shut);
          `EXPC_A_TBASE:    s_d.rdata = 32'(s_q.tbase);
          `EXPC_A_LONG_EXP: s_d.rdata = {1'b1, 5'h00, s_q.long_exposure_us};
          `EXPC_A_ACQ:      s_d.rdata = {s_q.single, s_q.multi, 14'h0000, s_q.count};
          `EXPC_A_FREE_RUN: s_d.rdata = {s_q.continuous_capture_bit, 31'h0};
          `EXPC_A_TRIG:     s_d.rdata = {1'b1, 5'h00, s_q.trig_on, 25'h0};
          default:          s_d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q       <= '0;
      s_q.st    <= EXPC_IDLE;
      s_q.tbase <= `EXPC_RST_TBASE;                      // RULE3
      s_q.shut  <= `EXPC_RST_SHUT;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // Sub-blocks
  expc_timer u_timer (
    .clk     (clk),
    .rstn    (rstn),
    .ld      (tmr_ld),
    .ld_us   (tmr_us),
    .us_tick (us_tick),
    .done    (tmr_done)
  );

  assign bif.valid = s_q.push;
  assign bif.data  = s_q.frame;

  expc_buf u_buf (
    .clk       (clk),
    .rstn      (rstn),
    .in_if     (bif),
    .out_valid (frm_valid),
    .out_ready (frm_ready),
    .out_data  (frm_data)
  );

  assign rsp_valid              = s_q.rsp;
  assign rsp_rdata              = s_q.rdata;
  assign sync_pulse             = s_q.sync;
  assign external_exposure_sync = s_q.ext_sync;
  assign exposing               = s_q.expo;

  // ========================================================================
  // Checks
  sequence lead_start_s;
    s_q.st == EXPC_LEAD && tmr_done;
  endsequence

  bcast_no_ack_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE22
    req_valid && req_node == `EXPC_BCAST_NODE |=> !rsp_valid)
    else $error("broadcast request acknowledged");
  tbase_reset_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE3
    $rose(rstn) |-> s_q.tbase == `EXPC_RST_TBASE) else $error("time base reset wrong");
  mirror_write_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE7
    req_valid && req_write && req_addr == `EXPC_A_SHUTTER && req_node == own_node
    |=> !s_q.long_act) else $error("shutter write not mirrored");
  long_drop_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE9
    req_valid && req_write && req_node == own_node && (req_addr == `EXPC_A_FMT_MODE
    || req_addr == `EXPC_A_FMT_FORMAT || req_addr == `EXPC_A_FMT_RATE)
    |=> !s_q.long_act) else $error("long exposure still active");
  lead_expose_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE14
    lead_start_s |=> exposing) else $error("integration did not start");
  sync_bound_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE14
    s_q.st == EXPC_SYNC |-> ##[1:400] sync_pulse) else $error("sync too late");
  arm_waits_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE12
    s_q.st == EXPC_ARM && !(trig_in && !s_q.trig_prev) |=> !exposing)
    else $error("exposure without trigger");
  free_run_keep_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE11
    s_q.continuous_capture_bit && s_q.single && s_d.push && !s_q.push
    && !(req_valid && req_write) |=> s_q.single) else $error("single bit cleared");
  multi_clear_a: assert property (@(posedge clk) disable iff (!rstn)  // RULE18
    s_q.multi && !s_q.continuous_capture_bit && s_q.count == 16'h0001
    && s_d.push && !s_q.push && !req_valid |=> !s_q.multi)
    else $error("multi-frame flag not cleared");
endmodule : expc_top

// >>> src/expc_params.svh
// Constants for the exposure and capture control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef EXPC_PARAMS_SVH
`define EXPC_PARAMS_SVH
// ==========================================================================
// Register byte addresses
`define EXPC_A_FMT_RATE   32'hF0F0_0600
`define EXPC_A_FMT_MODE   32'hF0F0_0604
`define EXPC_A_FMT_FORMAT 32'hF0F0_0608
`define EXPC_A_FREE_RUN   32'hF0F0_0614
`define EXPC_A_ACQ        32'hF0F0_061C
`define EXPC_A_SHUTTER    32'hF0F0_081C
`define EXPC_A_TRIG       32'hF0F0_0830
`define EXPC_A_TBASE      32'hF100_0208
`define EXPC_A_LONG_EXP   32'hF100_020C
// ==========================================================================
// Field positions (bit 0 of the bus is the MSB, so it is index 31 here)
`define EXPC_B_MSB        31
`define EXPC_B_MULTI      30
`define EXPC_B_TRIG_ON    25
`define EXPC_W_COUNT      16
`define EXPC_W_SHUT       12
`define EXPC_W_TBASE      8
`define EXPC_W_LONG       26
// ==========================================================================
// Reset values and timing
`define EXPC_RST_TBASE    8'h14
`define EXPC_RST_SHUT     12'h001
`define EXPC_BCAST_NODE   6'h3F
`define EXPC_CLK_NS       5
`define EXPC_US_NS        1000
`define EXPC_US_CYC       (`EXPC_US_NS / `EXPC_CLK_NS)
`define EXPC_OFFSET_US    27
`define EXPC_MIN_EXP_US   4
`define EXPC_LEAD_US      8
`define EXPC_SYNC_MAX_US  150
`define EXPC_XFER_NS      710000
`define EXPC_XFER_JIT_NS  62500
`define EXPC_XFER_MIN_US  ((`EXPC_XFER_NS - `EXPC_XFER_JIT_NS + `EXPC_US_NS - 1) / `EXPC_US_NS)
`define EXPC_BUS_CYC_US   125
`endif

// >>> src/expc_pkg.sv
// Types for the exposure and capture control block.
// Assumes the constants header is on the include path.
`include "expc_params.svh"
package expc_pkg;
  typedef enum logic [6:0] {
    EXPC_IDLE = 7'b000_0001,
    EXPC_SYNC = 7'b000_0010,
    EXPC_ARM  = 7'b000_0100,
    EXPC_LEAD = 7'b000_1000,
    EXPC_EXPO = 7'b001_0000,
    EXPC_READ = 7'b010_0000,
    EXPC_SEND = 7'b100_0000
  } expc_state_e;
endpackage : expc_pkg

// >>> src/expc_if.sv
// Carrier for one frame word between the capture sequencer and its buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface expc_if;
  logic        valid;
  logic        ready;
  logic [15:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : expc_if

// >>> src/expc_buf.sv
// Two-entry buffer for frame words; a stalled receiver loses no word.
// Assumes the source holds valid and data until ready.
`timescale 1ns/1ps
module expc_buf
  import expc_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rstn,
  expc_if.snk        in_if,
  output logic       out_valid,
  input  wire logic  out_ready,
  output logic [15:0] out_data
);
  typedef struct packed {
    logic [1:0]  used;
    logic        hv;
    logic [15:0] m0;
    logic [15:0] m1;
  } expc_buf_s;
  expc_buf_s s_q, s_d;

  // Entry 0 is the head; a word enters the first free slot.
  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop  = 1'b0;
    s_d  = s_q;
    push = in_if.valid && (s_q.used != 2'd2);
    pop  = out_ready && (s_q.used != 2'd0);
    if (pop) begin
      s_d.m0 = s_q.m1;
      s_d.used = s_q.used - 2'd1;
    end
    if (push) begin
      if (s_d.used == 2'd0) begin
        s_d.m0 = in_if.data;
      end else begin
        s_d.m1 = in_if.data;
      end
      s_d.used = s_d.used + 2'd1;
    end
    // Head-valid flag kept in a flip-flop so the output needs no decode.
    s_d.hv = (s_d.used != 2'd0);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_if.ready = (s_q.used != 2'd2);
  assign out_valid   = s_q.hv;
  assign out_data    = s_q.m0;

  buf_stall_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled word lost or changed");
endmodule : expc_buf

// >>> src/expc_timer.sv
// Microsecond tick divider and a microsecond down-counter.
// Assumes the clock runs at the rate named in the constants header.
`timescale 1ns/1ps
`include "expc_params.svh"
module expc_timer
  import expc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ld,
  input  wire logic [9:0] ld_us,
  output logic            us_tick,
  output logic            done
);
  typedef struct packed {
    logic [7:0] div;
    logic       tick;
    logic [9:0] cnt;
    logic       done;
  } expc_tmr_s;
  expc_tmr_s s_q, s_d;

  // One tick every microsecond; done pulses once the load has elapsed.
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    s_d.tick = (s_q.div == 8'(`EXPC_US_CYC - 1));
    s_d.div  = s_d.tick ? 8'h00 : s_q.div + 8'h01;
    if (ld) begin
      s_d.cnt = ld_us;
    end else if (s_q.tick && s_q.cnt != 10'h000) begin
      s_d.cnt  = s_q.cnt - 10'h001;
      s_d.done = (s_q.cnt == 10'h001);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign us_tick = s_q.tick;
  assign done    = s_q.done;

  tick_period_a: assert property (@(posedge clk) disable iff (!rstn)
    s_q.tick |=> !s_q.tick [*8]) else $error("microsecond tick too frequent");
endmodule : expc_timer

// >>> sim/expc_host.sv
// Host controller model: issues one register request at a time to the block.
// Assumes a single clock; requests change just after a rising edge.
`timescale 1ns/1ps
`include "expc_params.svh"
module expc_host #(
  parameter logic [5:0] NODE = 6'h05
) (
  input  wire logic        clk,
  input  wire logic        rsp_valid,
  input  wire logic [31:0] rsp_rdata,
  output logic             req_valid,
  output logic             req_write,
  output logic [5:0]       req_node,
  output logic [31:0]      req_addr,
  output logic [31:0]      req_wdata
);
  logic [31:0] rd_q;
  logic        got_q;

  // ==========================================================================
  // Bus idle state at time zero.
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_node  = 6'h00;
    req_addr  = 32'h0000_0000;
    req_wdata = 32'h0000_0000;
  end

  // One request held for one edge; the answer is looked for over two edges.
  task automatic xfer(input logic [5:0] nd, input logic wr, input logic [31:0] ad,
                      input logic [31:0] wd, output logic [31:0] rd, output logic got);
    got = 1'b0;
    rd  = 32'h0000_0000;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_write = wr;
    req_node  = nd;
    req_addr  = ad;
    req_wdata = wd;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req_addr  = ~req_addr;  // Released address and data lines toggle so no stale value lingers there.
    req_wdata = ~req_wdata;
    repeat (2) begin
      if (rsp_valid === 1'b1 && got !== 1'b1) begin
        got = 1'b1;
        rd  = rsp_rdata;
      end
      @(posedge clk);
      #1;
    end
  endtask : xfer

  // Standard shutter writes only ever carry a count from one up.
  task automatic shut_wr(input logic [11:0] v);
    logic [11:0] c;
    c = (v == 12'h000) ? 12'h001 : v;
    xfer(NODE, 1'b1, `EXPC_A_SHUTTER, {20'h0_0000, c}, rd_q, got_q);
  endtask : shut_wr

  // Externally triggered single frame: trigger on, free-run off, then request.
  task automatic trig_frame();
    xfer(NODE, 1'b1, `EXPC_A_TRIG, 32'h8200_0000, rd_q, got_q);
    xfer(NODE, 1'b1, `EXPC_A_FREE_RUN, 32'h0000_0000, rd_q, got_q);
    xfer(NODE, 1'b1, `EXPC_A_ACQ, 32'h8000_0000, rd_q, got_q);
  endtask : trig_frame

  // Withdraws an unused arming by clearing the request bit.
  task automatic cancel();
    xfer(NODE, 1'b1, `EXPC_A_ACQ, 32'h0000_0000, rd_q, got_q);
  endtask : cancel
endmodule : expc_host

// >>> sim/tb_exposure_and_capture_control.sv
// Bench for the exposure and capture control block.
// Assumes the host model issues requests; a monitor times sync and exposure.
`timescale 1ns/1ps
`include "expc_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_exposure_and_capture_control;
  localparam int         US   = `EXPC_US_CYC;
  localparam logic [5:0] NODE = 6'h05;
  logic        clk, rstn, trig_in, frm_ready, got, exp_q;
  logic        rsp_valid, sync_pulse, external_exposure_sync, exposing, frm_valid;
  logic        req_valid, req_write;
  logic [5:0]  req_node;
  logic [31:0] req_addr, req_wdata, rsp_rdata, rdat;
  logic [15:0] frm_data;
  int          fails, n_checks, cyc, t0, t_sync, t_rise, t_fall, t_trig;

  expc_top i_expc_top (.clk(clk), .rstn(rstn), .own_node(NODE), .req_valid(req_valid),
    .req_write(req_write), .req_node(req_node), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .trig_in(trig_in), .sync_pulse(sync_pulse),
    .external_exposure_sync(external_exposure_sync), .exposing(exposing),
    .frm_valid(frm_valid), .frm_ready(frm_ready), .frm_data(frm_data));
  expc_host #(.NODE(NODE)) i_expc_host (.clk(clk), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .req_valid(req_valid), .req_write(req_write),
    .req_node(req_node), .req_addr(req_addr), .req_wdata(req_wdata));

  // ==========================================================================
  // Clock, and a monitor that stamps sync and exposure edges and cuts hangs.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (sync_pulse === 1'b1) t_sync = cyc;
    if (exposing === 1'b1 && !exp_q) t_rise = cyc;
    if (exposing !== 1'b1 && exp_q) t_fall = cyc;
    exp_q = (exposing === 1'b1);
    if (cyc == 100000) begin
      fails++;
      $display("[FAIL] timeout expected 0 seen %0d", cyc);
      tally_and_finish();
    end
  end

  function automatic logic inr(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi);
  endfunction : inr

  task automatic tally_and_finish();
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_reset();
    rstn = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
  endtask : do_reset

  task automatic wr(input logic [31:0] ad, input logic [31:0] wd);
    i_expc_host.xfer(NODE, 1'b1, ad, wd, rdat, got);
  endtask : wr

  task automatic rd(input logic [31:0] ad);
    i_expc_host.xfer(NODE, 1'b0, ad, 32'h0000_0000, rdat, got);
  endtask : rd

  task automatic wait_arm();
    repeat (40000) begin
      if (external_exposure_sync === 1'b1) break;
      @(posedge clk);
      #1;
    end
  endtask : wait_arm

  task automatic pulse();
    @(posedge clk);
    #1;
    trig_in = 1'b1;
    t_trig  = cyc;
    repeat (2) @(posedge clk);
    #1;
    trig_in = 1'b0;
  endtask : pulse

  // Waits for the end of exposure, then judges sync (untriggered runs only), lead and width in us.
  task automatic chk_timing(input int e, input logic trg);
    int b;
    repeat (60000) begin
      if (t_fall > t0) break;
      @(posedge clk);
      #1;
    end
    b = trg ? t_trig : t_sync;
    if (!trg) `CHK("sync", 1'b1, inr(t_sync - t0, 0, `EXPC_SYNC_MAX_US * US))
    `CHK("lead", 1'b1, inr(t_rise - b, 7 * US, 9 * US + 2))
    `CHK("width", 1'b1, inr(t_fall - t_rise, (e - 1) * US, (e + 1) * US))
    `CHK("no_early_frame", 1'b0, frm_valid)
    `CHK("no_frame_word", 16'h0000, frm_data)
  endtask : chk_timing

  // ==========================================================================
  // Scenarios.
  task automatic s_regs();
    rd(`EXPC_A_TBASE);
    `CHK("tbase_rst", `EXPC_RST_TBASE, rdat[7:0])
    rd(`EXPC_A_SHUTTER);
    `CHK("shut_rst", `EXPC_RST_SHUT, rdat[11:0])
    i_expc_host.shut_wr(12'h064);
    rd(`EXPC_A_LONG_EXP);
    `CHK("mirror", 26'h000_07D0, rdat[25:0])
    `CHK("presence", 1'b1, rdat[31])
    wr(`EXPC_A_LONG_EXP, 32'h03FF_FFFF);
    rd(`EXPC_A_LONG_EXP);
    `CHK("long_max", 26'h3FF_FFFF, rdat[25:0])
    rd(`EXPC_A_SHUTTER);
    `CHK("no_back", 12'h064, rdat[11:0])
    rd(32'hF100_0FFC);
    `CHK("unmapped", 32'h0000_0000, rdat)
    i_expc_host.xfer(6'h3F, 1'b1, `EXPC_A_TBASE, 32'h0000_0005, rdat, got);
    `CHK("bc_quiet", 1'b0, got)
    i_expc_host.xfer(6'h09, 1'b1, `EXPC_A_TBASE, 32'h0000_0009, rdat, got);
    `CHK("other_quiet", 1'b0, got)
    rd(`EXPC_A_TBASE);
    `CHK("bc_acts", 8'h05, rdat[7:0])
  endtask : s_regs

  task automatic s_long();
    do_reset();
    wr(`EXPC_A_LONG_EXP, 32'h0000_03E8);
    t0 = cyc;
    wr(`EXPC_A_ACQ, 32'h8000_0000);
    // Shorten the exposure while it runs; the new value must act at once.
    repeat (40000) begin
      if (exposing === 1'b1) break;
      @(posedge clk);
      #1;
    end
    wr(`EXPC_A_LONG_EXP, 32'h0000_0003);
    chk_timing(31, 1'b0);
  endtask : s_long

  task automatic s_fmt();
    do_reset();
    wr(`EXPC_A_TBASE, 32'h0000_0005);
    i_expc_host.shut_wr(12'h002);
    wr(`EXPC_A_LONG_EXP, 32'h0000_0003);
    wr(`EXPC_A_FMT_FORMAT, 32'h0000_0000);
    t0 = cyc;
    wr(`EXPC_A_ACQ, 32'h8000_0000);
    chk_timing(37, 1'b0);
  endtask : s_fmt

  task automatic s_free();
    do_reset();
    t0 = cyc;
    wr(`EXPC_A_FREE_RUN, 32'h8000_0000);
    wr(`EXPC_A_ACQ, 32'h8000_0000);
    chk_timing(47, 1'b0);
    rd(`EXPC_A_ACQ);
    `CHK("single_kept", 1'b1, rdat[31])
    wr(`EXPC_A_FREE_RUN, 32'h0000_0000);
    rd(`EXPC_A_FREE_RUN);
    `CHK("free_off", 1'b0, rdat[31])
  endtask : s_free

  task automatic s_trig();
    do_reset();
    i_expc_host.trig_frame();
    wait_arm();
    `CHK("armed", 1'b1, external_exposure_sync)
    repeat (20 * US) @(posedge clk);
    #1;
    `CHK("held", 1'b0, exposing)
    i_expc_host.cancel();
    repeat (2) @(posedge clk);
    #1;
    `CHK("cancel", 1'b0, external_exposure_sync)
    wr(`EXPC_A_ACQ, 32'h8000_0000);
    wait_arm();
    t0 = cyc;
    pulse();
    chk_timing(47, 1'b1);
  endtask : s_trig

  task automatic s_multi();
    do_reset();
    wr(`EXPC_A_ACQ, 32'h4000_0000);
    repeat (10 * US) @(posedge clk);
    #1;
    `CHK("zero_idle", 1'b0, exposing)
    wr(`EXPC_A_TRIG, 32'h8200_0000);
    wr(`EXPC_A_ACQ, 32'h4000_0003);
    wait_arm();
    wr(`EXPC_A_ACQ, 32'h4000_0000);
    repeat (2) @(posedge clk);
    #1;
    `CHK("zero_stop", 1'b0, external_exposure_sync)
    wr(`EXPC_A_ACQ, 32'h4000_0002);
    wait_arm();
    `CHK("multi_arm", 1'b1, external_exposure_sync)
    t0 = cyc;
    pulse();
    chk_timing(47, 1'b1);
  endtask : s_multi

  // Main sequence: reset, then every scenario, then the verdict.
  initial begin
    rstn      = 1'b0;
    trig_in   = 1'b0;
    frm_ready = 1'b1;
    exp_q     = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    s_regs();
    s_long();
    s_fmt();
    s_free();
    s_trig();
    s_multi();
    tally_and_finish();
  end
endmodule : tb_exposure_and_capture_control
